// File: src/pll_cal_ctrl.sv
// pll calibration control: apb register, trigger edge, timed run, result routing
// assumes apb master per amba apb; analog pll consumes dac start and store strobes
`timescale 1ns/1ps
module pll_cal_ctrl
    import pll_cal_pkg::*;
#(
    parameter int WAIT0 = WAIT0_CYC,
    parameter int WAIT1 = WAIT1_CYC,
    parameter int WAIT2 = WAIT2_CYC,
    parameter int WAIT3 = WAIT3_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cal_active,
    output logic [3:0] dac_start_val,
    output logic store_a,
    output logic store_b
);
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    cal_ctrl_t ctrl_q;
    logic fset_sel_q;
    logic start_prev_q;
    cal_state_t state_q;
    cal_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [3:0] dac_q;
    logic dual_q;
    logic sel_q;
    store_t store_q;
    store_t store_d;

    function automatic logic [CNT_W-1:0] run_len(input logic [1:0] code);
        case (code)
            2'h0: run_len = CNT_W'(WAIT0);
            2'h1: run_len = CNT_W'(WAIT1);
            2'h2: run_len = CNT_W'(WAIT2);
            default: run_len = CNT_W'(WAIT3);
        endcase
    endfunction

    // apb decode
    wire logic access = psel & penable & ~pready_q;
    wire logic done_xfer = psel & penable & pready_q;
    wire logic hit_ctrl = paddr == CAL_CTRL_ADDR;
    wire logic hit_fsel = paddr == FSET_SEL_ADDR;
    wire logic hit_stat = paddr == CAL_STAT_ADDR;
    wire logic mapped = hit_ctrl | hit_fsel | hit_stat;
    wire logic wr_ctrl = done_xfer & pwrite & hit_ctrl;
    wire logic wr_fsel = done_xfer & pwrite & hit_fsel;
    wire logic [7:0] ctrl_rd = {ctrl_q.start, ctrl_q.dual, ctrl_q.wait_sel, 1'b0, ctrl_q.seed};
    wire logic [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                               hit_fsel ? {31'h00000000, fset_sel_q} :
                               hit_stat ? {29'h00000000, sel_q, dual_q, state_q == ST_RUN} :
                               32'h00000000;

    // RULE_01: trigger edge detect
    wire logic trig_rise = ctrl_q.start & ~start_prev_q;
    wire logic cal_end = (state_q == ST_RUN) && (cnt_q == '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= access;
            pslverr_q <= access & ~mapped;
            prdata_q <= (access & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // RULE_01: start bit resets to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= cal_ctrl_t'(CAL_CTRL_RST);
            fset_sel_q <= FSET_SEL_RST;
            start_prev_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= cal_ctrl_t'({pwdata[7:4], 1'b0, pwdata[2:0]});
            end
            if (wr_fsel) begin
                fset_sel_q <= pwdata[0];
            end
            start_prev_q <= ctrl_q.start;
        end
    end

    // RULE_06: retrigger ignored while running
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        store_d = '0;
        case (state_q)
            ST_IDLE: begin
                if (trig_rise) begin
                    state_d = ST_RUN;
                    // RULE_03: load selected duration
                    cnt_d = run_len(ctrl_q.wait_sel) - CNT_W'(1);
                end
            end
            ST_RUN: begin
                if (cal_end) begin
                    // RULE_06: back to idle
                    state_d = ST_IDLE;
                    // RULE_02: route results to sets
                    store_d.store_a = dual_q | ~sel_q;
                    store_d.store_b = dual_q | sel_q;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            store_q <= '0;
            dac_q <= 4'h0;
            dual_q <= 1'b0;
            sel_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            store_q <= store_d;
            if (state_q == ST_IDLE && trig_rise) begin
                // RULE_05: dac start is seed plus one
                dac_q <= {1'b0, ctrl_q.seed} + 4'h1;
                dual_q <= ctrl_q.dual;
                sel_q <= fset_sel_q;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cal_active = state_q == ST_RUN;
    assign dac_start_val = dac_q;
    assign store_a = store_q.store_a;
    assign store_b = store_q.store_b;

    // helper: cycles spent running
    logic [CNT_W-1:0] run_cnt_q;
    logic [CNT_W-1:0] exp_len_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_cnt_q <= '0;
            exp_len_q <= '0;
        end else begin
            if (state_q == ST_IDLE && trig_rise) begin
                run_cnt_q <= '0;
                exp_len_q <= run_len(ctrl_q.wait_sel);
            end else if (state_q == ST_RUN) begin
                run_cnt_q <= run_cnt_q + CNT_W'(1);
            end
        end
    end

    // RULE_01: edge starts run
    chk_edge_starts_run: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        (state_q == ST_IDLE && trig_rise) |=> cal_active ##1 cal_active)
        else $error("trigger edge did not start calibration");

    // RULE_02: store routing
    chk_store_routing: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        $fell(cal_active) |-> (store_a == (dual_q | ~sel_q)) && (store_b == (dual_q | sel_q))
            && (store_a | store_b))
        else $error("results routed to wrong frequency set");

    // RULE_03: run length exact
    chk_run_duration: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        $fell(cal_active) |-> run_cnt_q == exp_len_q)
        else $error("calibration run length wrong");

    // RULE_05: dac start value
    chk_dac_seed: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
        $rose(cal_active) |-> dac_start_val == {1'b0, $past(ctrl_q.seed)} + 4'h1)
        else $error("dac start value is not seed plus one");

    // RULE_06: retrigger ignored
    chk_no_retrigger: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        (cal_active && trig_rise && cnt_q != '0) |=> cal_active && $stable(dac_start_val)
            && cnt_q == $past(cnt_q) - CNT_W'(1))
        else $error("retrigger disturbed running calibration");

    // RULE_01: no run without an edge
    chk_no_level_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        (state_q == ST_IDLE && !trig_rise) |=> !cal_active)
        else $error("calibration started without a trigger edge");

    // RULE_06: run end gives idle and strobe
    chk_end_strobe: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        cal_end |=> !cal_active && (store_a || store_b))
        else $error("run end did not return to idle with a store strobe");

    // RULE_02: store strobes last one cycle
    chk_store_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        (store_a || store_b) |=> !(store_a || store_b))
        else $error("store strobe held for more than one cycle");

    cov_dual_store: cover property (@(posedge pclk) disable iff (!presetn)
        store_a && store_b);
    cov_single_b: cover property (@(posedge pclk) disable iff (!presetn)
        store_b && !store_a);
    cov_retrigger: cover property (@(posedge pclk) disable iff (!presetn)
        cal_active && trig_rise);
    cov_single_a: cover property (@(posedge pclk) disable iff (!presetn)
        store_a && !store_b);
    cov_seed_max: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(cal_active) && dac_start_val == 4'h8);
endmodule

// File: src/pll_cal_pkg.sv
// constants, field layouts and types for the pll calibration control block
// assumes a 32-bit apb master and a core clock that is the reference clock
// Function
// RULE_01: trigger bit rising edge starts calibration; resets zero
// RULE_02: store-both writes A and B, else selected set
// RULE_03: wait field selects run length in periods
// RULE_04: software should program wait field to code 3
// RULE_05: dac iteration starts at seed plus one
// RULE_06: ignore retrigger while running; idle after duration
package pll_cal_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] CAL_CTRL_IDX = 8'h1B;
    localparam logic [7:0] FSET_SEL_IDX = 8'h3D;
    localparam logic [7:0] CAL_STAT_IDX = 8'h3E;
    localparam logic [9:0] CAL_CTRL_ADDR = {CAL_CTRL_IDX, 2'b00};
    localparam logic [9:0] FSET_SEL_ADDR = {FSET_SEL_IDX, 2'b00};
    localparam logic [9:0] CAL_STAT_ADDR = {CAL_STAT_IDX, 2'b00};
    // field positions of the calibration control register
    localparam int START_BIT = 7;
    localparam int DUAL_BIT = 6;
    localparam int WAIT_LSB = 4;
    localparam int RSVD_BIT = 3;
    localparam int SEED_LSB = 0;
    // reset values
    localparam logic [7:0] CAL_CTRL_RST = 8'h05;
    localparam logic FSET_SEL_RST = 1'b0;
    // run lengths in reference-clock periods
    localparam int WAIT0_PERIODS = 90000;
    localparam int WAIT1_PERIODS = 110000;
    localparam int WAIT2_PERIODS = 130000;
    localparam int WAIT3_PERIODS = 200000;
    // core clock is the reference clock, one cycle per period
    localparam int CYC_PER_REF = 1;
    localparam int WAIT0_CYC = WAIT0_PERIODS * CYC_PER_REF;
    localparam int WAIT1_CYC = WAIT1_PERIODS * CYC_PER_REF;
    localparam int WAIT2_CYC = WAIT2_PERIODS * CYC_PER_REF;
    localparam int WAIT3_CYC = WAIT3_PERIODS * CYC_PER_REF;
    localparam int CNT_W = 18;

    typedef struct packed {
        logic start;
        logic dual;
        logic [1:0] wait_sel;
        logic rsvd;
        logic [2:0] seed;
    } cal_ctrl_t;

    typedef struct packed {
        logic store_a;
        logic store_b;
    } store_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } cal_state_t;
endpackage

// File: tb/test_pll_calibration_control.sv
// self-checking bench for the pll calibration control block
// assumes short run lengths 10,12,14,20 set through the parameters
`timescale 1ns/1ps
module test_pll_calibration_control;
    import pll_cal_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cal_active, store_a, store_b;
    logic [3:0] dac_start_val;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int compares = 0;
    int act_n, sa_n, sb_n;

    pll_cal_ctrl #(.WAIT0(10), .WAIT1(12), .WAIT2(14), .WAIT3(20)) i_pll_cal_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cal_active(cal_active),
        .dac_start_val(dac_start_val), .store_a(store_a), .store_b(store_b));

    always #10 pclk = ~pclk;

    // counts run cycles and store pulses
    always @(negedge pclk) begin
        if (cal_active === 1'b1) act_n++;
        if (store_a === 1'b1) sa_n++;
        if (store_b === 1'b1) sb_n++;
    end

    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run(input logic [1:0] w, input logic dual, input logic sel,
                       input logic [2:0] seed, input logic retrig);
        int n;
        int exp_n;
        exp_n = (w == 2'h0) ? 10 : (w == 2'h1) ? 12 : (w == 2'h2) ? 14 : 20;
        n = 0;
        apb(1'b1, FSET_SEL_ADDR, {31'h0, sel});
        apb(1'b0, FSET_SEL_ADDR, 32'h0);
        chk("fset_sel_readback", {31'h0, sel}, rd);
        apb(1'b1, CAL_CTRL_ADDR, {24'h0, 1'b0, dual, w, 1'b0, seed});
        act_n = 0;
        sa_n = 0;
        sb_n = 0;
        apb(1'b1, CAL_CTRL_ADDR, {24'h0, 1'b1, dual, w, 1'b0, seed});
        while (cal_active !== 1'b1 && n < 10) begin
            @(negedge pclk);
            n++;
        end
        chk("cal_active_start", 32'h1, {31'h0, cal_active});
        chk("dac_start_val", {28'h0, {1'b0, seed} + 4'h1}, {28'h0, dac_start_val});
        apb(1'b0, CAL_STAT_ADDR, 32'h0);
        chk("status_latched", {29'h0, sel, dual, 1'b1}, rd);
        if (retrig) begin
            apb(1'b1, CAL_CTRL_ADDR, {24'h0, 1'b0, ~dual, w, 1'b0, ~seed});
            apb(1'b1, CAL_CTRL_ADDR, {24'h0, 1'b1, ~dual, w, 1'b0, ~seed});
        end
        repeat (30) @(negedge pclk);
        chk("run_cycles", exp_n, act_n);
        chk("cal_active_idle", 32'h0, {31'h0, cal_active});
        chk("store_a_pulses", (dual || !sel) ? 32'h1 : 32'h0, sa_n);
        chk("store_b_pulses", (dual || sel) ? 32'h1 : 32'h0, sb_n);
        chk("dac_held", {28'h0, {1'b0, seed} + 4'h1}, {28'h0, dac_start_val});
    endtask

    task automatic reset_mid_run();
        apb(1'b1, CAL_CTRL_ADDR, 32'h00000030);
        apb(1'b1, CAL_CTRL_ADDR, 32'h000000B0);
        repeat (4) @(posedge pclk);
        chk("reset_run_up", 32'h1, {31'h0, cal_active});
        sa_n = 0;
        sb_n = 0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset_active", 32'h0, {31'h0, cal_active});
        chk("reset_dac", 32'h0, {28'h0, dac_start_val});
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, CAL_CTRL_ADDR, 32'h0);
        chk("reset_ctrl", 32'h05, rd);
        repeat (30) @(negedge pclk);
        chk("reset_idle", 32'h0, {31'h0, cal_active});
        chk("reset_store", 32'h0, sa_n + sb_n);
    endtask

    initial begin
        repeat (3000) @(posedge pclk);
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CAL_CTRL_ADDR, 32'h0);
        chk("ctrl_reset", 32'h05, rd);
        chk("trigger_reset", 32'h0, {31'h0, cal_active});
        apb(1'b0, 10'h000, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_rd", 32'h0, rd);
        apb(1'b1, CAL_CTRL_ADDR, 32'h0000007F);
        apb(1'b0, CAL_CTRL_ADDR, 32'h0);
        chk("ctrl_readback", 32'h77, rd);
        run(2'h0, 1'b0, 1'b0, 3'h0, 1'b0);
        run(2'h1, 1'b0, 1'b1, 3'h7, 1'b0);
        run(2'h2, 1'b1, 1'b0, 3'h3, 1'b0);
        run(2'h3, 1'b1, 1'b1, 3'h4, 1'b1);
        reset_mid_run();
        end_sim();
    end
endmodule
